/* logic/quad_valve_pwm_interleave.sv */
// four-channel interleaved pwm generator with ahb-lite register slave
`timescale 1ns/1ps
module quad_valve_pwm_interleave (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [39:0] measuredCurrent,
  output logic      [3:0]  lowSideChannel,
  output logic             edgeRateFast
);

  ////////////////////////////////////////////////////////////////////////
  // bus slave state

  valve_pwm_pkg::bus_phase_t phase_reg;
  logic [7:0]  addrLatch_reg;
  logic [9:0]  target_reg [4];
  logic [31:0] ctrl_reg;

  logic        addrValid;
  assign addrValid = hsel && hready && htrans[1];

  // address phase capture; one-cycle data phase with no wait states
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      phase_reg     <= valve_pwm_pkg::BUS_IDLE;
      addrLatch_reg <= 8'h00;
    end else if (addrValid) begin
      phase_reg     <= hwrite ? valve_pwm_pkg::BUS_WRITE
                              : valve_pwm_pkg::BUS_READ;
      addrLatch_reg <= haddr[7:0];
    end else if (hready) begin
      phase_reg     <= valve_pwm_pkg::BUS_IDLE;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // register writes

  // targets hold 10 bits; duty is the upper 8
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < 4; i++) begin
        target_reg[i] <= valve_pwm_pkg::TARGET_RST;
      end
      ctrl_reg <= valve_pwm_pkg::CTRL_RST;
    end else if (phase_reg == valve_pwm_pkg::BUS_WRITE) begin
      case (addrLatch_reg)
        valve_pwm_pkg::DUTY0_OFS: target_reg[0] <= hwdata[9:0]; // R3
        valve_pwm_pkg::DUTY1_OFS: target_reg[1] <= hwdata[9:0]; // R3
        valve_pwm_pkg::DUTY2_OFS: target_reg[2] <= hwdata[9:0]; // R3
        valve_pwm_pkg::DUTY3_OFS: target_reg[3] <= hwdata[9:0]; // R3
        valve_pwm_pkg::CTRL_OFS:  ctrl_reg <= {24'h000000, hwdata[7:0]};
        default: ;
      endcase
    end
  end

  logic [2:0] rateSel;
  logic       regDis12;
  logic       regDis34;
  logic       readbackSel;
  logic       firstDutyCtl;
  assign rateSel      = ctrl_reg[valve_pwm_pkg::RATE_LSB +: 3]; // R8 R9
  assign regDis12     = ctrl_reg[valve_pwm_pkg::REGDIS12_BIT];
  assign regDis34     = ctrl_reg[valve_pwm_pkg::REGDIS34_BIT];
  assign readbackSel  = ctrl_reg[valve_pwm_pkg::READBACK_BIT];
  assign firstDutyCtl = ctrl_reg[valve_pwm_pkg::FIRSTDUTY_BIT];

  // edge rate registered from the control bit to the slope control of the stage
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      edgeRateFast <= 1'b0;
    end else begin
      edgeRateFast <= ctrl_reg[valve_pwm_pkg::EDGE_BIT]; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timebase: step prescaler and 8-bit phase counter

  logic [11:0] prescale_reg;
  logic [7:0]  phase8_reg;
  logic        stepTick;
  logic [11:0] stepLen;

  assign stepLen  = valve_pwm_pkg::step_clocks(rateSel); // R17
  assign stepTick = (prescale_reg >= stepLen - 12'h001);

  // one period is 256 steps of the rate-dependent length
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prescale_reg <= 12'h000;
      phase8_reg   <= 8'h00;
    end else if (stepTick) begin
      prescale_reg <= 12'h000;
      phase8_reg   <= phase8_reg + 8'h01; // R17
    end else begin
      prescale_reg <= prescale_reg + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel interleaved pwm

  logic [7:0] duty_reg [4];
  logic [3:0] started_reg;
  logic [3:0] pwmMode;
  logic [7:0] chPhase [4];
  logic [3:0] periodStart;

  assign pwmMode = {regDis34, regDis34, regDis12, regDis12}; // R12

  // channel n counts from the shared phase shifted by n quarters
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      chPhase[n]     = phase8_reg - 8'(n * 64); // R7
      periodStart[n] = stepTick && (chPhase[n] == 8'hFF);
    end
  end

  // duty latched from the target only at that channel's period boundary; cleared at once while its pair is out of pwm mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int n = 0; n < 4; n++) begin
        duty_reg[n] <= 8'h00;
      end
      started_reg <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (!pwmMode[n]) begin
          duty_reg[n]    <= 8'h00;
          started_reg[n] <= 1'b0;
        end else if (periodStart[n]) begin // R16
          started_reg[n] <= 1'b1;
          // first period uses the programmed duty only if first-duty bit set, else zero
          if (!started_reg[n] && !firstDutyCtl) begin
            duty_reg[n] <= 8'h00; // R15
          end else begin
            duty_reg[n] <= target_reg[n][9:2]; // R1 R12
          end
        end
      end
    end
  end

  // switch commands from the interleave comparator
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lowSideChannel <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (duty_reg[n] == 8'hFF) begin
          lowSideChannel[n] <= 1'b1; // R4
        end else if (duty_reg[n] == 8'h00) begin
          lowSideChannel[n] <= 1'b0; // R5
        end else begin
          lowSideChannel[n] <= (chPhase[n] < duty_reg[n]); // R2 R6 R11
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] rdMux;
  logic [1:0]  rdIdx;

  assign rdIdx = addrLatch_reg[3:2];

  // duty readback, or measured current when readback select is set and the channel is in pwm mode
  always_comb begin
    rdMux = 32'h0000_0000;
    case (addrLatch_reg)
      valve_pwm_pkg::DUTY0_OFS, valve_pwm_pkg::DUTY1_OFS,
      valve_pwm_pkg::DUTY2_OFS, valve_pwm_pkg::DUTY3_OFS: begin
        if (pwmMode[rdIdx] && readbackSel) begin
          rdMux = {22'h000000, measuredCurrent[rdIdx*10 +: 10]}; // R14
        end else begin
          rdMux = {22'h000000, target_reg[rdIdx]}; // R13
        end
      end
      valve_pwm_pkg::CTRL_OFS:   rdMux = ctrl_reg;
      valve_pwm_pkg::STATUS_OFS: rdMux = {16'h0000, started_reg,
                                          lowSideChannel, phase8_reg};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  assign hrdata = (phase_reg == valve_pwm_pkg::BUS_READ) ? rdMux
                                                         : 32'h0000_0000;

endmodule

/* logic/valve_pwm_pkg.sv */
// constants and types for the four-channel interleaved valve pwm block
//
// Behaviour
// R1: host writes an 8-bit duty per channel; it sets the channel on-time.
// R2: each duty step adds 1/256 of the period, range 0 to 100 percent.
// R3: four independent 8-bit duty settings, each written separately.
// R4: duty all ones holds the channel on for the whole period.
// R5: duty zero holds the channel off.
// R6: codes 1..0xFE give on-time of code/256 of the period.
// R7: each channel period starts a quarter period after the previous one.
// R8: 3-bit rate select maps eight codes to 3.0 to 5.0 kHz.
// R9: rate select resets to 000, nominal 3.9 kHz.
// R10: edge-rate bit, 1 selects fast slopes, 0 slow ones.
// R11: outputs come from the interleave logic, never straight from writes.
// R12: regulation-disable per pair enables pwm; upper 8 of 10 bits is duty.
// R13: readback select 0 returns the programmed duty setting.
// R14: readback select 1 returns the measured current value; the code does so only for channels in pwm mode, else the duty setting.
// R15: first-period duty control bit governs the duty of the first period.
// R16: new duty is loaded only at the start of the channel's next period.
// R17: period counter sized per rate code; on-phase is duty/256 of it.
package valve_pwm_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;

  // frequencies in Hz, indexed by the rate code
  localparam int unsigned FREQ_HZ_111 = 3000;
  localparam int unsigned FREQ_HZ_110 = 3200;
  localparam int unsigned FREQ_HZ_101 = 3400;
  localparam int unsigned FREQ_HZ_100 = 3600;
  localparam int unsigned FREQ_HZ_000 = 3900;
  localparam int unsigned FREQ_HZ_011 = 4200;
  localparam int unsigned FREQ_HZ_001 = 4500;
  localparam int unsigned FREQ_HZ_010 = 5000;

  // a period is 256 duty steps; step_clocks gives the clocks per step
  localparam int unsigned DUTY_STEPS = 256;

  // register byte offsets
  localparam logic [7:0] DUTY0_OFS    = 8'h00;
  localparam logic [7:0] DUTY1_OFS    = 8'h04;
  localparam logic [7:0] DUTY2_OFS    = 8'h08;
  localparam logic [7:0] DUTY3_OFS    = 8'h0C;
  localparam logic [7:0] CTRL_OFS     = 8'h10;
  localparam logic [7:0] STATUS_OFS   = 8'h14;

  // control register fields
  localparam int unsigned RATE_LSB     = 0;
  localparam int unsigned EDGE_BIT     = 3;
  localparam int unsigned REGDIS12_BIT = 4;
  localparam int unsigned REGDIS34_BIT = 5;
  localparam int unsigned READBACK_BIT = 6;
  localparam int unsigned FIRSTDUTY_BIT = 7;

  // reset values
  localparam logic [2:0]  RATE_RST     = 3'h0;
  localparam logic [9:0]  TARGET_RST   = 10'h000;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  // step length in clocks for a rate frequency (rounded down)
  function automatic logic [11:0] step_clocks(input logic [2:0] rate);
    int unsigned f;
    f = FREQ_HZ_000;
    case (rate)
      3'h7: f = FREQ_HZ_111;
      3'h6: f = FREQ_HZ_110;
      3'h5: f = FREQ_HZ_101;
      3'h4: f = FREQ_HZ_100;
      3'h0: f = FREQ_HZ_000;
      3'h3: f = FREQ_HZ_011;
      3'h1: f = FREQ_HZ_001;
      default: f = FREQ_HZ_010;
    endcase
    step_clocks = 12'(CLK_HZ / (f * DUTY_STEPS));
  endfunction

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_t;

endpackage

/* dv/valve_pwm_monitor.sv */
// concurrent checks on the valve pwm block ports
`timescale 1ns/1ps
module valve_pwm_monitor (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [3:0]  lowSideChannel,
  input wire logic        edgeRateFast
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic rdPh;
  logic wrPh;
  // data phase trackers
  always_ff @(posedge clk_sys) begin
    rdPh <= rstn && hsel && hready && htrans[1] && !hwrite;
    wrPh <= rstn && hsel && hready && htrans[1] && hwrite;
  end
  sequence sTake;
    hsel && hready && htrans[1];
  endsequence
  AST_READY: assert property (hreadyout)
    else $error("wait state inserted");
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("error response");
  AST_RD_IDLE: assert property (!rdPh |-> hrdata == 32'h0)
    else $error("read data outside read phase");
  AST_WR_DATA: assert property (sTake ##0 hwrite |=> hrdata == 32'h0)
    else $error("read data in write phase");
  AST_RST_OFF: assert property (!$past(rstn) |->
    lowSideChannel == 4'h0 && !edgeRateFast)
    else $error("outputs active after reset");
  AST_EDGE: assert property ($changed(edgeRateFast) |->
    $past(wrPh) || $past(wrPh, 2))
    else $error("edge rate moved without write");
  // a phase never lasts less than eight clocks
  for (genvar i = 0; i < 4; i++) begin : g_ch
    AST_HOLD_ON: assert property ($rose(lowSideChannel[i]) |=>
      lowSideChannel[i] [*7])
      else $error("on phase cut short");
    AST_HOLD_OFF: assert property ($fell(lowSideChannel[i]) |=>
      !lowSideChannel[i] [*7])
      else $error("off phase cut short");
  end
endmodule
bind quad_valve_pwm_interleave valve_pwm_monitor valve_pwm_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .lowSideChannel(lowSideChannel), .edgeRateFast(edgeRateFast));

/* dv/host_model.sv */
// ahb-lite host that writes and reads the pwm block registers
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk_sys,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // one single word transfer, read data taken at the data phase edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk_sys); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* dv/tb.sv */
// self-checking bench for the interleaved valve pwm block
`timescale 1ns/1ps
module tb;
  localparam int STEP = 100_000_000 / (5000 * 256); // rate code 010
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [39:0] measuredCurrent = 40'h3_5A96_C3A5;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  lowSideChannel;
  logic        edgeRateFast;
  logic [31:0] q;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          tRise;
  logic [31:0] tgt [4] = '{32'h200, 32'h3FF, 32'h000, 32'h100};
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  quad_valve_pwm_interleave quad_valve_pwm_interleave_i (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .measuredCurrent(measuredCurrent),
    .lowSideChannel(lowSideChannel), .edgeRateFast(edgeRateFast));
  host_model host_model_i (
    .clk_sys(clk_sys), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host_model_i.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [31:0] a);
    host_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  // wait until a channel output reaches a level
  task automatic wait_ch(input int ch, input logic lvl);
    do @(posedge clk_sys); while (lowSideChannel[ch] !== lvl);
  endtask
  task automatic close_out;
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({27'h0, edgeRateFast, lowSideChannel}, 32'h0);
    rd(32'h10);
    chk(q, 32'h0);
    rd(32'h20);
    chk(q, 32'h0);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 4; i++) wr(32'(4 * i), tgt[i]);
    wr(32'h10, 32'hFA);
    rd(32'h04);
    chk(q, {22'h0, measuredCurrent[19:10]});
    wr(32'h10, 32'hBA);
    for (int i = 0; i < 4; i++) begin
      rd(32'(4 * i));
      chk(q, tgt[i]);
    end
    chk({31'h0, edgeRateFast}, 32'h1);
  endtask
  task automatic t_pwm;
    wait_ch(0, 1'b0);
    wait_ch(0, 1'b1);
    tRise = cyc;
    wr(32'h00, 32'h080);
    wait_ch(0, 1'b0);
    chk(32'(cyc - tRise), 32'(128 * STEP));
    wait_ch(3, 1'b1);
    chk(32'(cyc - tRise), 32'(192 * STEP));
    chk({28'h0, lowSideChannel}, 32'hA);
    wait_ch(0, 1'b1);
    chk(32'(cyc - tRise), 32'(256 * STEP));
    tRise = cyc;
    wait_ch(0, 1'b0);
    chk(32'(cyc - tRise), 32'(32 * STEP));
  endtask
  // pairs off, then back on with the first period skipped
  task automatic t_first;
    int tEn;
    wr(32'h10, 32'h02);
    repeat (3) @(posedge clk_sys);
    chk({27'h0, edgeRateFast, lowSideChannel}, 32'h0);
    wr(32'h10, 32'h3A);
    tEn = cyc;
    wait_ch(1, 1'b1);
    chk({31'h0, (cyc - tEn) > 256 * STEP}, 32'h1);
    chk({31'h0, (cyc - tEn) < 512 * STEP + 8}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_regs();
    t_pwm();
    t_first();
    close_out();
  end
  // watchdog sized for under five pwm periods at the fastest rate
  initial begin
    #950_000;
    mismatches++;
    close_out();
  end
endmodule
